// >>> crri_defs.svh
// Register indices, reset values and vectors of the core register bank
`ifndef CRRI_DEFS_SVH
`define CRRI_DEFS_SVH
`define CRRI_IDX_TOP_UPPER 5'h00
`define CRRI_IDX_TOP_HIGH 5'h01
`define CRRI_IDX_TOP_LOW 5'h02
`define CRRI_IDX_STACK_PTR 5'h03
`define CRRI_IDX_LATCH_UPPER 5'h04
`define CRRI_IDX_LATCH_HIGH 5'h05
`define CRRI_IDX_PC_LOW 5'h06
`define CRRI_IDX_TBL_UPPER 5'h07
`define CRRI_IDX_TBL_HIGH 5'h08
`define CRRI_IDX_TBL_LOW 5'h09
`define CRRI_IDX_TBL_DATA 5'h0a
`define CRRI_IDX_PROD_HIGH 5'h0b
`define CRRI_IDX_PROD_LOW 5'h0c
`define CRRI_IDX_ICTL_FIRST 5'h0d
`define CRRI_IDX_ICTL_SECOND 5'h0e
`define CRRI_IDX_ICTL_THIRD 5'h0f
`define CRRI_IDX_FSEL0_HIGH 5'h10
`define CRRI_IDX_FSEL0_LOW 5'h11
`define CRRI_IDX_WORK_ACC 5'h12
`define CRRI_IDX_IND_FIRST 5'h13
`define CRRI_IDX_IND_LAST 5'h1c
`define CRRI_IDX_PORT_IN 5'h1d
`define CRRI_IDX_PORT_LATCH 5'h1e
`define CRRI_IDX_PORT_DIR 5'h1f
`define CRRI_ICTL_FIRST_RST 7'h00
`define CRRI_ICTL_SECOND_RST 8'hff
`define CRRI_ICTL_THIRD_RST 8'hc0
`define CRRI_SP_FLAG_MASK 8'hc0
`define CRRI_SP_IMPL_MASK 8'hdf
`define CRRI_PORT_FREE_MASK 8'h3f
`define CRRI_GLOBAL_HIGH_IRQ_ENABLE_BIT 7
`define CRRI_GLOBAL_LOW_IRQ_ENABLE_BIT 6
`define CRRI_SP_FULL_BIT 7
`define CRRI_VEC_HIGH 21'h000008
`define CRRI_VEC_LOW 21'h000018
`define CRRI_PC_STEP 21'h000002
`define CRRI_SP_LAST 5'h1f
`endif

// >>> crri_pkg.sv
// Types shared by the core register bank
package crri_pkg;
  typedef enum logic [1:0] {init_none, init_por, init_other, init_wake} crri_init_e;
  typedef logic [20:0] crri_pc_t;
endpackage : crri_pkg

// >>> crri_bus_if.sv
// Decoded register access between bus slave and register bank
interface crri_bus_if;
  logic wr_stb;
  logic [4:0] idx;
  logic [7:0] wdata;
  logic [7:0] rd_data;
  modport slave_side (output wr_stb, output idx, output wdata, input rd_data);
  modport core_side (input wr_stb, input idx, input wdata, output rd_data);
endinterface : crri_bus_if

// >>> crri_apb_slave.sv
// APB slave: zero wait states, decoded strobe and registered read data
module crri_apb_slave (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  crri_bus_if.slave_side bus
);
  logic [31:0] prdata_q;
  wire setup = psel && !penable;
  wire access = psel && penable;
  // Only 32 aligned words exist; anything else errors
  wire hit = (paddr[31:7] == 25'h0000000) && (paddr[1:0] == 2'h0);
  assign bus.idx = paddr[6:2];
  assign bus.wdata = pwdata[7:0];
  assign bus.wr_stb = access && pwrite && hit;
  assign pready = 1'b1;
  assign pslverr = access && !hit;
  assign prdata = prdata_q;
  // Read data is caught in the setup cycle so it comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h00000000;
    end else if (setup) begin
      prdata_q <= {24'h000000, hit ? bus.rd_data : 8'h00};
    end
  end
endmodule : crri_apb_slave

// >>> crri_wake_seq.sv
// Wake-up program counter, vector and stack push selection
`include "crri_defs.svh"
module crri_wake_seq (
  input wire crri_pkg::crri_pc_t pc,
  input wire logic [7:0] sp,
  input wire logic global_high_irq_enable,
  input wire logic global_low_irq_enable,
  input wire logic by_irq,
  input wire logic irq_high,
  output crri_pkg::crri_pc_t wake_pc,
  output crri_pkg::crri_pc_t ret_pc,
  output logic push,
  output logic [7:0] sp_next
);
  wire at_last = (sp[4:0] == `CRRI_SP_LAST);
  assign ret_pc = pc + `CRRI_PC_STEP;
  assign push = by_irq && (global_high_irq_enable || global_low_irq_enable);
  // Vector on an enabled interrupt, else resume past the sleep
  assign wake_pc = !push ? ret_pc : irq_high ? `CRRI_VEC_HIGH : `CRRI_VEC_LOW;
  // A push at the last slot keeps the pointer and flags the overflow
  assign sp_next = at_last ? (sp | 8'h80) : {sp[7:6], 1'b0, sp[4:0] + 5'h01};
endmodule : crri_wake_seq

// >>> crri_core_regs.sv
// Core register bank with reset-class and wake-up initialization
`include "crri_defs.svh"
module crri_core_regs (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rst_por_pulse,
  input wire logic rst_other_pulse,
  input wire logic wake_pulse,
  input wire logic wake_by_irq,
  input wire logic wake_irq_high,
  input wire logic [7:0] wake_flags_first,
  input wire logic [7:0] wake_flags_third,
  input wire logic osc_frees_pins,
  input wire logic [7:0] first_port_pins,
  output logic [20:0] pc_value,
  output logic [7:0] stack_ptr_value,
  output logic [7:0] port_latch_out,
  output logic [7:0] port_dir_out
);
  crri_bus_if bus ();

  crri_apb_slave u_apb (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .bus(bus)
  );

  crri_pkg::crri_init_e init_cls;
  crri_pkg::crri_pc_t tos_q, tos_d, pc_q, pc_d;
  crri_pkg::crri_pc_t wake_pc, ret_pc;
  logic [7:0] sp_q, sp_d, sp_next;
  logic [4:0] lat_u_q, lat_u_d;
  logic [7:0] lat_h_q, lat_h_d;
  logic [21:0] tbl_q, tbl_d;
  logic [7:0] table_data_latch_q, table_data_latch_d;
  logic [7:1] ic1_q, ic1_d;
  logic [7:0] ic2_q, ic2_d, ic3_q, ic3_d;
  logic [7:0] plat_q, plat_d, pdir_q, pdir_d;
  logic ic1_b0_q;
  logic [7:0] prod_h_q, prod_l_q, acc_q, fsel_l_q;
  logic [3:0] fsel_h_q;
  logic push;
  logic [7:0] rd_mux;

  // Power-on outranks the other class, which outranks a wake-up
  assign init_cls = rst_por_pulse ? crri_pkg::init_por :
                    rst_other_pulse ? crri_pkg::init_other :
                    wake_pulse ? crri_pkg::init_wake : crri_pkg::init_none;

  wire wr = bus.wr_stb;
  wire [7:0] wd = bus.wdata;
  wire port_mask_on = !osc_frees_pins;
  wire [7:0] port_mask = port_mask_on ? `CRRI_PORT_FREE_MASK : 8'hff;
  wire ind_hit = (bus.idx >= `CRRI_IDX_IND_FIRST) && (bus.idx <= `CRRI_IDX_IND_LAST);
  wire global_high_irq_enable = ic1_q[`CRRI_GLOBAL_HIGH_IRQ_ENABLE_BIT];
  wire global_low_irq_enable = ic1_q[`CRRI_GLOBAL_LOW_IRQ_ENABLE_BIT];

  crri_wake_seq u_wake (
    .pc(pc_q),
    .sp(sp_q),
    .global_high_irq_enable(global_high_irq_enable),
    .global_low_irq_enable(global_low_irq_enable),
    .by_irq(wake_by_irq),
    .irq_high(wake_irq_high),
    .wake_pc(wake_pc),
    .ret_pc(ret_pc),
    .push(push),
    .sp_next(sp_next)
  );

  always_comb begin
    tos_d = tos_q;
    sp_d = sp_q;
    pc_d = pc_q;
    lat_u_d = lat_u_q;
    lat_h_d = lat_h_q;
    tbl_d = tbl_q;
    table_data_latch_d = table_data_latch_q;
    ic1_d = ic1_q;
    ic2_d = ic2_q;
    ic3_d = ic3_q;
    plat_d = plat_q;
    pdir_d = pdir_q;
    if (wr) begin
      unique case (bus.idx)
        `CRRI_IDX_TOP_UPPER: tos_d[20:16] = wd[4:0];
        `CRRI_IDX_TOP_HIGH: tos_d[15:8] = wd;
        `CRRI_IDX_TOP_LOW: tos_d[7:0] = wd;
        `CRRI_IDX_STACK_PTR: sp_d = wd & `CRRI_SP_IMPL_MASK;
        `CRRI_IDX_LATCH_UPPER: lat_u_d = wd[4:0];
        `CRRI_IDX_LATCH_HIGH: lat_h_d = wd;
        // Writing the low byte jumps, pulling the upper bits from the latches
        `CRRI_IDX_PC_LOW: pc_d = {lat_u_q, lat_h_q, wd};
        `CRRI_IDX_TBL_UPPER: tbl_d[21:16] = wd[5:0];
        `CRRI_IDX_TBL_HIGH: tbl_d[15:8] = wd;
        `CRRI_IDX_TBL_LOW: tbl_d[7:0] = wd;
        `CRRI_IDX_TBL_DATA: table_data_latch_d = wd;
        `CRRI_IDX_ICTL_FIRST: ic1_d = wd[7:1];
        `CRRI_IDX_ICTL_SECOND: ic2_d = wd;
        `CRRI_IDX_ICTL_THIRD: ic3_d = wd;
        `CRRI_IDX_PORT_LATCH: plat_d = wd;
        `CRRI_IDX_PORT_DIR: pdir_d = wd;
        default: ;
      endcase
    end
    unique case (init_cls)
      crri_pkg::init_por, crri_pkg::init_other: begin
        tos_d = 21'h000000;
        // Power-on keeps the overflow flags so software can still see them
        sp_d = (init_cls == crri_pkg::init_por) ? (sp_q & `CRRI_SP_FLAG_MASK) : 8'h00;
        lat_u_d = 5'h00;
        lat_h_d = 8'h00;
        pc_d = 21'h000000;
        tbl_d = 22'h000000;
        table_data_latch_d = 8'h00;
        ic1_d = `CRRI_ICTL_FIRST_RST;
        ic2_d = `CRRI_ICTL_SECOND_RST;
        ic3_d = `CRRI_ICTL_THIRD_RST;
      end
      crri_pkg::init_wake: begin
        pc_d = wake_pc;
        if (push) begin
          tos_d = ret_pc;
          sp_d = sp_next;
        end
        // Waking flags win over a write landing in the same cycle
        ic1_d = ic1_d | wake_flags_first[7:1];
        ic3_d = ic3_d | wake_flags_third;
      end
      crri_pkg::init_none: ;
    endcase
    plat_d = plat_d & port_mask;
    pdir_d = pdir_d & port_mask;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tos_q <= 21'h000000;
      sp_q <= 8'h00;
      pc_q <= 21'h000000;
      lat_u_q <= 5'h00;
      lat_h_q <= 8'h00;
      tbl_q <= 22'h000000;
      table_data_latch_q <= 8'h00;
      ic1_q <= `CRRI_ICTL_FIRST_RST;
      ic2_q <= `CRRI_ICTL_SECOND_RST;
      ic3_q <= `CRRI_ICTL_THIRD_RST;
      plat_q <= 8'h00;
      pdir_q <= 8'h00;
    end else begin
      tos_q <= tos_d;
      sp_q <= sp_d;
      pc_q <= pc_d;
      lat_u_q <= lat_u_d;
      lat_h_q <= lat_h_d;
      tbl_q <= tbl_d;
      table_data_latch_q <= table_data_latch_d;
      ic1_q <= ic1_d;
      ic2_q <= ic2_d;
      ic3_q <= ic3_d;
      plat_q <= plat_d;
      pdir_q <= pdir_d;
    end
  end

  // Data registers carry no reset at all; they power up unknown
  always_ff @(posedge pclk) begin
    if (wr && bus.idx == `CRRI_IDX_PROD_HIGH) prod_h_q <= wd;
    if (wr && bus.idx == `CRRI_IDX_PROD_LOW) prod_l_q <= wd;
    if (wr && bus.idx == `CRRI_IDX_WORK_ACC) acc_q <= wd;
    if (wr && bus.idx == `CRRI_IDX_FSEL0_HIGH) fsel_h_q <= wd[3:0];
    if (wr && bus.idx == `CRRI_IDX_FSEL0_LOW) fsel_l_q <= wd;
    if (init_cls == crri_pkg::init_wake && wake_flags_first[0]) begin
      ic1_b0_q <= 1'b1;
    end else if (wr && bus.idx == `CRRI_IDX_ICTL_FIRST) begin
      ic1_b0_q <= wd[0];
    end
  end

  always_comb begin
    rd_mux = 8'h00;
    unique case (bus.idx)
      `CRRI_IDX_TOP_UPPER: rd_mux = {3'h0, tos_q[20:16]};
      `CRRI_IDX_TOP_HIGH: rd_mux = tos_q[15:8];
      `CRRI_IDX_TOP_LOW: rd_mux = tos_q[7:0];
      `CRRI_IDX_STACK_PTR: rd_mux = sp_q & `CRRI_SP_IMPL_MASK;
      `CRRI_IDX_LATCH_UPPER: rd_mux = {3'h0, lat_u_q};
      `CRRI_IDX_LATCH_HIGH: rd_mux = lat_h_q;
      `CRRI_IDX_PC_LOW: rd_mux = pc_q[7:0];
      `CRRI_IDX_TBL_UPPER: rd_mux = {2'h0, tbl_q[21:16]};
      `CRRI_IDX_TBL_HIGH: rd_mux = tbl_q[15:8];
      `CRRI_IDX_TBL_LOW: rd_mux = tbl_q[7:0];
      `CRRI_IDX_TBL_DATA: rd_mux = table_data_latch_q;
      `CRRI_IDX_PROD_HIGH: rd_mux = prod_h_q;
      `CRRI_IDX_PROD_LOW: rd_mux = prod_l_q;
      `CRRI_IDX_ICTL_FIRST: rd_mux = {ic1_q, ic1_b0_q};
      `CRRI_IDX_ICTL_SECOND: rd_mux = ic2_q;
      `CRRI_IDX_ICTL_THIRD: rd_mux = ic3_q;
      `CRRI_IDX_FSEL0_HIGH: rd_mux = {4'h0, fsel_h_q};
      `CRRI_IDX_FSEL0_LOW: rd_mux = fsel_l_q;
      `CRRI_IDX_WORK_ACC: rd_mux = acc_q;
      `CRRI_IDX_PORT_IN: rd_mux = first_port_pins & port_mask;
      `CRRI_IDX_PORT_LATCH: rd_mux = plat_q;
      `CRRI_IDX_PORT_DIR: rd_mux = pdir_q;
      // Indirect windows are address decodes only, nothing to read back
      default: rd_mux = 8'h00;
    endcase
  end

  assign bus.rd_data = rd_mux;
  assign pc_value = pc_q;
  assign stack_ptr_value = sp_q;
  assign port_latch_out = plat_q;
  assign port_dir_out = pdir_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  wire any_rst = rst_por_pulse || rst_other_pulse;

  chk_top_reset_clear: assert property (any_rst
    |=> tos_q == 21'h000000 && lat_u_q == 5'h00)
    else $error("stack top or latch not cleared by reset");

  chk_top_wake_hold: assert property (wake_pulse && !any_rst && !push && !wr
    |=> tos_q == $past(tos_q))
    else $error("stack top changed by plain wake-up");

  chk_sp_por_keep: assert property (rst_por_pulse
    |=> sp_q == ($past(sp_q) & 8'hc0))
    else $error("stack pointer wrong after power-on");

  chk_sp_other_zero: assert property (rst_other_pulse && !rst_por_pulse
    |=> sp_q == 8'h00)
    else $error("stack pointer not cleared by other reset");

  chk_sp_wake_hold: assert property (wake_pulse && !any_rst && !push && !wr
    |=> sp_q == $past(sp_q))
    else $error("stack pointer changed by plain wake-up");

  chk_pc_latch_clear: assert property (any_rst
    |=> lat_h_q == 8'h00 && pc_q[7:0] == 8'h00)
    else $error("pc latch or low byte not cleared");

  chk_latch_wake_hold: assert property (wake_pulse && !any_rst && !wr
    |=> lat_u_q == $past(lat_u_q) && lat_h_q == $past(lat_h_q))
    else $error("pc latch changed by wake-up");

  chk_pc_reset_zero: assert property (any_rst
    |=> pc_q == 21'h000000)
    else $error("program counter not cleared by reset");

  chk_pc_wake_step: assert property (wake_pulse && !any_rst && !push
    |=> pc_q == $past(pc_q) + 21'h000002)
    else $error("wake-up did not advance pc by two");

  chk_tbl_reset: assert property (any_rst
    |=> tbl_q == 22'h000000 && table_data_latch_q == 8'h00)
    else $error("table pointer not cleared");

  chk_tbl_wake_hold: assert property (wake_pulse && !any_rst && !wr
    |=> tbl_q == $past(tbl_q) && table_data_latch_q == $past(table_data_latch_q))
    else $error("table pointer changed by wake-up");

  // Identity compare: these may still be unknown from power-up and must stay so
  chk_data_keep: assert property ((rst_other_pulse || wake_pulse) && !rst_por_pulse && !wr
    |=> acc_q === $past(acc_q) && prod_l_q === $past(prod_l_q) && prod_h_q === $past(prod_h_q)
        && fsel_h_q === $past(fsel_h_q) && fsel_l_q === $past(fsel_l_q))
    else $error("data register disturbed by reset");

  chk_ictl_bit0_keep: assert property (rst_other_pulse && !rst_por_pulse && !wr
    |=> ic1_b0_q === $past(ic1_b0_q))
    else $error("interrupt control bit 0 changed by reset");

  chk_ictl_second_set: assert property (any_rst
    |=> ic2_q == 8'hff)
    else $error("second interrupt control not set by reset");

  chk_ictl_reset: assert property (any_rst
    |=> ic1_q == 7'h00 && ic2_q == 8'hff && ic3_q == 8'hc0)
    else $error("interrupt control reset value wrong");

  chk_wake_flags: assert property (wake_pulse && !any_rst
    |=> (ic3_q & $past(wake_flags_third)) == $past(wake_flags_third))
    else $error("waking flag not left set");

  chk_wake_first_flags: assert property (wake_pulse && !any_rst
    |=> (ic1_q & $past(wake_flags_first[7:1])) == $past(wake_flags_first[7:1]))
    else $error("waking flag in first control not left set");

  chk_vector_load: assert property (wake_pulse && !any_rst && push && wake_irq_high
    |=> pc_q == 21'h000008)
    else $error("high vector not loaded");

  chk_vector_low: assert property (wake_pulse && !any_rst && push && !wake_irq_high
    |=> pc_q == 21'h000018)
    else $error("low vector not loaded");

  chk_vector_push: assert property (wake_pulse && !any_rst && push
    |=> tos_q == $past(pc_q) + 21'h000002)
    else $error("return address not pushed");

  chk_sp_push_step: assert property (wake_pulse && !any_rst && push && sp_q[4:0] != 5'h1f
    |=> sp_q[4:0] == $past(sp_q[4:0]) + 5'h01)
    else $error("stack pointer not advanced by push");

  chk_indirect_zero: assert property (psel && penable && ind_hit
    |-> prdata == 32'h00000000)
    else $error("indirect address returned data");

  chk_read_upper_zero: assert property (psel && penable
    |-> prdata[31:8] == 24'h000000)
    else $error("unimplemented read bits not zero");

  chk_port_mask: assert property (port_mask_on [*2]
    |-> plat_q[7:6] == 2'h0 && pdir_q[7:6] == 2'h0)
    else $error("port bits 6 and 7 not disabled");

  chk_idle_hold: assert property (!any_rst && !wake_pulse && !wr
    |=> pc_q == $past(pc_q) && tos_q == $past(tos_q) && tbl_q == $past(tbl_q) && ic2_q == $past(ic2_q))
    else $error("register changed without an event");
endmodule : crri_core_regs

// >>> testbench.sv
// Self-checking bench for the core register bank: reset classes, wake-up and register bus
`include "crri_defs.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata;
  logic rst_por_pulse, rst_other_pulse, wake_pulse, wake_by_irq, wake_irq_high, osc_frees_pins;
  logic [7:0] wake_flags_first, wake_flags_third, first_port_pins;
  logic [7:0] stack_ptr_value, port_latch_out, port_dir_out;
  logic [20:0] pc_value;
  int mismatches = 0;
  int tests_run = 0;

  crri_core_regs crri_core_regs_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rst_por_pulse(rst_por_pulse),
    .rst_other_pulse(rst_other_pulse), .wake_pulse(wake_pulse), .wake_by_irq(wake_by_irq),
    .wake_irq_high(wake_irq_high), .wake_flags_first(wake_flags_first),
    .wake_flags_third(wake_flags_third), .osc_frees_pins(osc_frees_pins),
    .first_port_pins(first_port_pins), .pc_value(pc_value), .stack_ptr_value(stack_ptr_value),
    .port_latch_out(port_latch_out), .port_dir_out(port_dir_out));

  task automatic end_sim();
    if (mismatches == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Master waits on pready rather than assuming zero wait states
  task automatic xfer(input logic wr, input logic [31:0] addr, input logic [7:0] wd,
                      output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= {24'h000000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    // Ends once pready is seen high at an edge; the watchdog covers a pready that never rises
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [4:0] idx, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    xfer(1'b1, {25'h0000000, idx, 2'h0}, d, r, e);
    chk({31'h00000000, e}, 32'h00000000);
  endtask : wr

  task automatic rd(input logic [4:0] idx, input logic [31:0] mask, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    xfer(1'b0, {25'h0000000, idx, 2'h0}, 8'h00, r, e);
    chk(r & mask, exp);
    chk({31'h00000000, e}, 32'h00000000);
  endtask : rd

  // Values land on the same edge that sees the strobe high
  task automatic pulse(input logic por, input logic oth, input logic wk, input logic irq,
                       input logic hi, input logic [7:0] f1, input logic [7:0] f3);
    @(posedge pclk);
    rst_por_pulse <= por;
    rst_other_pulse <= oth;
    wake_pulse <= wk;
    wake_by_irq <= irq;
    wake_irq_high <= hi;
    wake_flags_first <= f1;
    wake_flags_third <= f3;
    @(posedge pclk);
    rst_por_pulse <= 1'b0;
    rst_other_pulse <= 1'b0;
    wake_pulse <= 1'b0;
    wake_flags_first <= 8'h00;
    wake_flags_third <= 8'h00;
    #1;
  endtask : pulse

  task automatic check_cleared(input logic [7:0] sp_exp);
    for (int i = 0; i <= 10; i++) begin
      if (i != 3) rd(i[4:0], 32'hffffffff, 32'h00000000);
    end
    rd(`CRRI_IDX_STACK_PTR, 32'hffffffff, {24'h000000, sp_exp});
    rd(`CRRI_IDX_ICTL_FIRST, 32'h000000fe, 32'h00000000);
    rd(`CRRI_IDX_ICTL_SECOND, 32'hffffffff, 32'h000000ff);
    rd(`CRRI_IDX_ICTL_THIRD, 32'hffffffff, 32'h000000c0);
  endtask : check_cleared

  task automatic t_unimpl();
    logic [31:0] r;
    logic e;
    wr(`CRRI_IDX_TOP_UPPER, 8'hff);
    wr(`CRRI_IDX_TBL_UPPER, 8'hff);
    wr(`CRRI_IDX_FSEL0_HIGH, 8'hff);
    rd(`CRRI_IDX_TOP_UPPER, 32'hffffffff, 32'h0000001f);
    rd(`CRRI_IDX_TBL_UPPER, 32'hffffffff, 32'h0000003f);
    rd(`CRRI_IDX_FSEL0_HIGH, 32'hffffffff, 32'h0000000f);
    for (int i = 19; i <= 28; i++) begin
      wr(i[4:0], 8'hff);
      rd(i[4:0], 32'hffffffff, 32'h00000000);
    end
    xfer(1'b0, 32'h00000080, 8'h00, r, e);
    chk({r[30:0], e}, 32'h00000001);
    xfer(1'b1, 32'h00000002, 8'hff, r, e);
    chk({31'h00000000, e}, 32'h00000001);
  endtask : t_unimpl

  task automatic t_port();
    osc_frees_pins <= 1'b0;
    first_port_pins <= 8'hff;
    wr(`CRRI_IDX_PORT_LATCH, 8'hff);
    wr(`CRRI_IDX_PORT_DIR, 8'hff);
    rd(`CRRI_IDX_PORT_IN, 32'hffffffff, 32'h0000003f);
    rd(`CRRI_IDX_PORT_DIR, 32'hffffffff, 32'h0000003f);
    chk({24'h000000, port_latch_out}, 32'h0000003f);
    chk({24'h000000, port_dir_out}, 32'h0000003f);
    osc_frees_pins <= 1'b1;
    wr(`CRRI_IDX_PORT_LATCH, 8'hff);
    rd(`CRRI_IDX_PORT_IN, 32'hffffffff, 32'h000000ff);
    chk({24'h000000, port_latch_out}, 32'h000000ff);
  endtask : t_port

  task automatic t_wake_plain();
    wr(`CRRI_IDX_LATCH_UPPER, 8'h01);
    wr(`CRRI_IDX_LATCH_HIGH, 8'h23);
    wr(`CRRI_IDX_PC_LOW, 8'h44);
    pulse(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 8'h00, 8'h00);
    chk({11'h000, pc_value}, 32'h00012346);
    rd(`CRRI_IDX_LATCH_UPPER, 32'hffffffff, 32'h00000001);
    rd(`CRRI_IDX_TOP_LOW, 32'hffffffff, 32'h00000000);
    chk({24'h000000, stack_ptr_value}, 32'h00000000);
  endtask : t_wake_plain

  task automatic t_wake_vector();
    wr(`CRRI_IDX_ICTL_FIRST, 8'h80);
    pulse(1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 8'h02, 8'h01);
    chk({11'h000, pc_value}, 32'h00000008);
    chk({24'h000000, stack_ptr_value}, 32'h00000001);
    rd(`CRRI_IDX_TOP_UPPER, 32'hffffffff, 32'h00000001);
    rd(`CRRI_IDX_TOP_HIGH, 32'hffffffff, 32'h00000023);
    rd(`CRRI_IDX_TOP_LOW, 32'hffffffff, 32'h00000048);
    rd(`CRRI_IDX_ICTL_FIRST, 32'hffffffff, 32'h00000082);
    rd(`CRRI_IDX_ICTL_THIRD, 32'hffffffff, 32'h000000c1);
    wr(`CRRI_IDX_ICTL_FIRST, 8'h40);
    pulse(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 8'h00, 8'h00);
    chk({11'h000, pc_value}, 32'h00000018);
    chk({24'h000000, stack_ptr_value}, 32'h00000002);
    rd(`CRRI_IDX_TOP_LOW, 32'hffffffff, 32'h0000000a);
    // Interrupt wake with both global enables off resumes in line
    wr(`CRRI_IDX_ICTL_FIRST, 8'h00);
    pulse(1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 8'h00, 8'h00);
    chk({11'h000, pc_value}, 32'h0000001a);
    chk({24'h000000, stack_ptr_value}, 32'h00000002);
  endtask : t_wake_vector

  task automatic t_other_reset();
    wr(`CRRI_IDX_PROD_HIGH, 8'h5a);
    wr(`CRRI_IDX_WORK_ACC, 8'ha5);
    wr(`CRRI_IDX_FSEL0_HIGH, 8'h0c);
    wr(`CRRI_IDX_ICTL_FIRST, 8'hff);
    wr(`CRRI_IDX_ICTL_SECOND, 8'h00);
    wr(`CRRI_IDX_ICTL_THIRD, 8'h00);
    wr(`CRRI_IDX_STACK_PTR, 8'hc3);
    wr(`CRRI_IDX_TBL_DATA, 8'hff);
    pulse(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 8'h00, 8'h00);
    chk({11'h000, pc_value}, 32'h00000000);
    check_cleared(8'h00);
    rd(`CRRI_IDX_ICTL_FIRST, 32'hffffffff, 32'h00000001);
    rd(`CRRI_IDX_PROD_HIGH, 32'hffffffff, 32'h0000005a);
    rd(`CRRI_IDX_WORK_ACC, 32'hffffffff, 32'h000000a5);
    rd(`CRRI_IDX_FSEL0_HIGH, 32'hffffffff, 32'h0000000c);
  endtask : t_other_reset

  task automatic t_por_reset();
    wr(`CRRI_IDX_STACK_PTR, 8'he3);
    rd(`CRRI_IDX_STACK_PTR, 32'hffffffff, 32'h000000c3);
    wr(`CRRI_IDX_ICTL_SECOND, 8'h00);
    // Every strobe at once: power-on must win over the other class and the wake
    pulse(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 8'hff, 8'hff);
    check_cleared(8'hc0);
  endtask : t_por_reset

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // Whole run is a few hundred cycles; the limit leaves wide margin
  initial begin
    #(40 * 5000);
    mismatches++;
    end_sim();
  end

  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, rst_por_pulse, rst_other_pulse, wake_pulse} = 6'h00;
    {wake_by_irq, wake_irq_high, osc_frees_pins} = 3'h0;
    paddr = 32'h00000000;
    pwdata = 32'h00000000;
    wake_flags_first = 8'h00;
    wake_flags_third = 8'h00;
    first_port_pins = 8'h00;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    check_cleared(8'h00);
    t_unimpl();
    t_port();
    t_wake_plain();
    t_wake_vector();
    t_other_reset();
    t_por_reset();
    end_sim();
  end
endmodule : testbench
